// ---- src/tecc_top.sv ----
// timer/event counter control: three counters behind an AXI4-Lite slave
// assumes counter pins and the 32768Hz oscillator are asynchronous to CLK
//
// The AXI4-Lite register port was left to the implementer.
`include "tecc_consts.svh"
`default_nettype none
module tecc_top #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic              CLK,
    input  wire logic              SRST,
    // axi4-lite write
    input  wire logic [ADDR_W-1:0] AWADDR,
    input  wire logic              AWVALID,
    output var  logic              AWREADY,
    input  wire logic [31:0]       WDATA,
    input  wire logic [3:0]        WSTRB,
    input  wire logic              WVALID,
    output var  logic              WREADY,
    output var  logic [1:0]        BRESP,
    output var  logic              BVALID,
    input  wire logic              BREADY,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] ARADDR,
    input  wire logic              ARVALID,
    output var  logic              ARREADY,
    output var  logic [31:0]       RDATA,
    output var  logic [1:0]        RRESP,
    output var  logic              RVALID,
    input  wire logic              RREADY,
    // pins
    input  wire logic [2:0]        CTR_EVENT_PIN,
    input  wire logic              RTC_OSC_IN,
    output var  logic [1:0]        FREQ_DIVIDER_OUT,
    output var  logic [`TECC_PSC_W-1:0] PWM_PRESCALE,
    output var  logic              IRQ
);
    import tecc_pkg::*;

    function automatic logic psc_tick(input logic [`TECC_PSC_W-1:0] p, input logic [2:0] code);
        logic [`TECC_PSC_W-1:0] m;
        m = `TECC_PSC_W'((8'h01 << code) - 8'h01);
        return (p & m) == m;
    endfunction

    function automatic logic idx_known(input logic [9:0] i);
        return i == `TECC_CTRL0_IDX || i == `TECC_CTRL1_IDX || i == `TECC_CTRL2_IDX
            || (i >= `TECC_PRE0_IDX && i <= `TECC_MASK_IDX);
    endfunction

    tecc_cnt_if #(.W(16)) c0 ();
    tecc_cnt_if #(.W(16)) c1 ();
    tecc_cnt_if #(.W(8))  c2 ();

    logic [7:0]             ctrl_q [3];
    logic [15:0]            pre0_q;
    logic [15:0]            pre1_q;
    logic [7:0]             pre2_q;
    logic [2:0]             ld_q;
    logic [2:0]             stat_q;
    logic [2:0]             mask_q;
    logic [`TECC_PSC_W-1:0] psc_q;
    logic [2:0]             pin_s1_q;
    logic [2:0]             pin_s2_q;
    logic [2:0]             pin_d_q;
    logic                   rtc_s1_q;
    logic                   rtc_s2_q;
    logic                   rtc_d_q;
    logic [1:0]             pfd_q;
    logic                   irq_q;
    logic                   aw_full_q;
    logic                   w_full_q;
    logic [9:0]             widx_q;
    logic [31:0]            wdata_q;
    logic [3:0]             wstrb_q;
    logic                   awready_q;
    logic                   wready_q;
    logic                   bvalid_q;
    logic [1:0]             bresp_q;
    logic                   arready_q;
    logic                   rvalid_q;
    logic [31:0]            rdata_q;
    logic [1:0]             rresp_q;
    logic [9:0]             ridx_q;
    logic                   wr_en;
    logic [9:0]             ridx;
    logic [31:0]            rd_word;
    logic [2:0]             rise;
    logic [2:0]             fall;
    logic                   rtc_tick;
    logic [2:0]             ovf;
    logic [2:0]             done;

    ////////////////////////////////////////////////////////////////////////
    // synchronisers and edge detection
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
            pin_d_q  <= 3'h0;
            rtc_s1_q <= 1'b0;
            rtc_s2_q <= 1'b0;
            rtc_d_q  <= 1'b0;
        end else begin
            pin_s1_q <= CTR_EVENT_PIN;
            pin_s2_q <= pin_s1_q;
            pin_d_q  <= pin_s2_q;
            rtc_s1_q <= RTC_OSC_IN;
            rtc_s2_q <= rtc_s1_q;
            rtc_d_q  <= rtc_s2_q;
        end
    end

    assign rise     = pin_s2_q & ~pin_d_q;
    assign fall     = ~pin_s2_q & pin_d_q;
    assign rtc_tick = rtc_s2_q & ~rtc_d_q;

    // free-running prescaler, shared with the pwm stage
    always_ff @(posedge CLK) begin
        if (SRST) psc_q <= '0;
        else psc_q <= psc_q + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // counter channels
    assign c0.tick = psc_tick(psc_q, ctrl_q[0][`TECC_PSC_LSB +: 3]);
    assign c2.tick = psc_tick(psc_q, ctrl_q[2][`TECC_PSC_LSB +: 3]);
    assign c1.tick = ctrl_q[1][`TECC_SRC_BIT] ? rtc_tick : psc_tick(psc_q, `TECC_DIV4_CODE);
    assign c0.rise = rise[0];
    assign c1.rise = rise[1];
    assign c2.rise = rise[2];
    assign c0.fall = fall[0];
    assign c1.fall = fall[1];
    assign c2.fall = fall[2];
    assign c0.mode = tecc_mode_t'(ctrl_q[0][`TECC_MODE_LSB +: 2]);
    assign c1.mode = tecc_mode_t'(ctrl_q[1][`TECC_MODE_LSB +: 2]);
    assign c2.mode = tecc_mode_t'(ctrl_q[2][`TECC_MODE_LSB +: 2]);
    assign c0.edge_sel = ctrl_q[0][`TECC_EDGE_BIT];
    assign c1.edge_sel = ctrl_q[1][`TECC_EDGE_BIT];
    assign c2.edge_sel = ctrl_q[2][`TECC_EDGE_BIT];
    assign c0.run  = ctrl_q[0][`TECC_RUN_BIT];
    assign c1.run  = ctrl_q[1][`TECC_RUN_BIT];
    assign c2.run  = ctrl_q[2][`TECC_RUN_BIT];
    assign c0.load = ld_q[0];
    assign c1.load = ld_q[1];
    assign c2.load = ld_q[2];
    assign c0.preload = pre0_q;
    assign c1.preload = pre1_q;
    assign c2.preload = pre2_q;
    assign ovf  = {c2.ovf, c1.ovf, c0.ovf};
    assign done = {c2.done, c1.done, c0.done};

    tecc_counter #(.W(16)) u_ctr0 (.clk(CLK), .srst(SRST), .c(c0.chn));
    tecc_counter #(.W(16)) u_ctr1 (.clk(CLK), .srst(SRST), .c(c1.chn));
    tecc_counter #(.W(8))  u_ctr2 (.clk(CLK), .srst(SRST), .c(c2.chn));

    ////////////////////////////////////////////////////////////////////////
    // frequency divider outputs: half the overflow rate
    always_ff @(posedge CLK) begin
        if (SRST) pfd_q <= 2'h0;
        else pfd_q <= pfd_q ^ ovf[1:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel
    assign wr_en = aw_full_q && w_full_q && !bvalid_q;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            aw_full_q <= 1'b0;
            awready_q <= 1'b0;
            widx_q    <= 10'h000;
        end else if (AWVALID && awready_q) begin
            aw_full_q <= 1'b1;
            awready_q <= 1'b0;
            widx_q    <= AWADDR[11:2];
        end else if (wr_en) begin
            aw_full_q <= 1'b0;
        end else if (!aw_full_q && !bvalid_q) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            w_full_q <= 1'b0;
            wready_q <= 1'b0;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end else if (WVALID && wready_q) begin
            w_full_q <= 1'b1;
            wready_q <= 1'b0;
            wdata_q  <= WDATA;
            wstrb_q  <= WSTRB;
        end else if (wr_en) begin
            w_full_q <= 1'b0;
        end else if (!w_full_q && !bvalid_q) begin
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `TECC_RESP_OKAY;
        end else if (wr_en) begin
            bvalid_q <= 1'b1;
            bresp_q  <= idx_known(widx_q) ? `TECC_RESP_OKAY : `TECC_RESP_SLVERR;
        end else if (BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers; a software write beats the automatic run clear
    for (genvar i = 0; i < 3; i++) begin : g_ctrl
        localparam logic [9:0] IDX  = i == 0 ? `TECC_CTRL0_IDX : i == 1 ? `TECC_CTRL1_IDX : `TECC_CTRL2_IDX;
        localparam logic [7:0] MSK  = i == 1 ? `TECC_CTRL1_MASK : `TECC_CTRL02_MASK;
        always_ff @(posedge CLK) begin
            if (SRST) begin
                ctrl_q[i] <= `TECC_CTRL_RST;
            end else if (wr_en && widx_q == IDX && wstrb_q[0]) begin
                ctrl_q[i] <= wdata_q[7:0] & MSK;
            end else if (done[i]) begin
                ctrl_q[i][`TECC_RUN_BIT] <= 1'b0;
            end
        end
    end

    // preload registers; a write while stopped also loads the counter
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pre0_q <= 16'h0000;
            pre1_q <= 16'h0000;
            pre2_q <= 8'h00;
            ld_q   <= 3'h0;
        end else begin
            ld_q <= 3'h0;
            if (wr_en && widx_q == `TECC_PRE0_IDX) begin
                if (wstrb_q[0]) pre0_q[7:0]  <= wdata_q[7:0];
                if (wstrb_q[1]) pre0_q[15:8] <= wdata_q[15:8];
                ld_q[0] <= !c0.run;
            end
            if (wr_en && widx_q == `TECC_PRE1_IDX) begin
                if (wstrb_q[0]) pre1_q[7:0]  <= wdata_q[7:0];
                if (wstrb_q[1]) pre1_q[15:8] <= wdata_q[15:8];
                ld_q[1] <= !c1.run;
            end
            if (wr_en && widx_q == `TECC_PRE2_IDX && wstrb_q[0]) begin
                pre2_q  <= wdata_q[7:0];
                ld_q[2] <= !c2.run;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status (write one to clear, a new overflow wins) and mask
    always_ff @(posedge CLK) begin
        if (SRST) begin
            stat_q <= 3'h0;
        end else if (wr_en && widx_q == `TECC_STAT_IDX && wstrb_q[0]) begin
            stat_q <= (stat_q & ~wdata_q[2:0]) | ovf;
        end else begin
            stat_q <= stat_q | ovf;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) mask_q <= 3'h0;
        else if (wr_en && widx_q == `TECC_MASK_IDX && wstrb_q[0]) mask_q <= wdata_q[2:0];
    end

    always_ff @(posedge CLK) begin
        if (SRST) irq_q <= 1'b0;
        else irq_q <= |(stat_q & mask_q);
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel
    assign ridx = ARADDR[11:2];

    always_comb begin
        rd_word = 32'h0000_0000;
        case (ridx)
            `TECC_CTRL0_IDX: rd_word[7:0] = ctrl_q[0];
            `TECC_CTRL1_IDX: rd_word[7:0] = ctrl_q[1];
            `TECC_CTRL2_IDX: rd_word[7:0] = ctrl_q[2];
            `TECC_PRE0_IDX:  rd_word[15:0] = pre0_q;
            `TECC_PRE1_IDX:  rd_word[15:0] = pre1_q;
            `TECC_PRE2_IDX:  rd_word[7:0] = pre2_q;
            `TECC_CNT0_IDX:  rd_word[15:0] = c0.cnt;
            `TECC_CNT1_IDX:  rd_word[15:0] = c1.cnt;
            `TECC_CNT2_IDX:  rd_word[7:0] = c2.cnt;
            `TECC_STAT_IDX:  rd_word[2:0] = stat_q;
            `TECC_MASK_IDX:  rd_word[2:0] = mask_q;
            default:         rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= `TECC_RESP_OKAY;
            ridx_q    <= 10'h000;
        end else if (ARVALID && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_word;
            rresp_q   <= idx_known(ridx) ? `TECC_RESP_OKAY : `TECC_RESP_SLVERR;
            ridx_q    <= ridx;
        end else if (rvalid_q && RREADY) begin
            rvalid_q  <= 1'b0;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    assign AWREADY          = awready_q;
    assign WREADY           = wready_q;
    assign BVALID           = bvalid_q;
    assign BRESP            = bresp_q;
    assign ARREADY          = arready_q;
    assign RVALID           = rvalid_q;
    assign RDATA            = rdata_q;
    assign RRESP            = rresp_q;
    assign FREQ_DIVIDER_OUT = pfd_q;
    assign PWM_PRESCALE     = psc_q;
    assign IRQ              = irq_q;

    ////////////////////////////////////////////////////////////////////////
    AST_PRESC: assert property (@(posedge CLK) disable iff (SRST)
        !SRST |=> psc_q == $past(psc_q) + 1'b1)
        else $error("prescaler did not advance");
    AST_RD_ZERO: assert property (@(posedge CLK) disable iff (SRST)
        rvalid_q && ridx_q == `TECC_CTRL1_IDX |-> rdata_q[2:0] == 3'h0)
        else $error("unused control bits read nonzero");
    AST_RUN_CLR: assert property (@(posedge CLK) disable iff (SRST)
        c1.done && !wr_en |=> !ctrl_q[1][`TECC_RUN_BIT])
        else $error("run not cleared after measurement");
    AST_PFD: assert property (@(posedge CLK) disable iff (SRST)
        c0.ovf |=> pfd_q[0] != $past(pfd_q[0]))
        else $error("divider output missed overflow");
    AST_IRQ: assert property (@(posedge CLK) disable iff (SRST)
        (stat_q & mask_q) != 3'h0 |=> IRQ)
        else $error("unmasked status did not raise interrupt");
    AST_STAT: assert property (@(posedge CLK) disable iff (SRST)
        ovf != 3'h0 |=> (stat_q & $past(ovf)) == $past(ovf))
        else $error("overflow did not set status");
endmodule // tecc_top
`default_nettype wire

// ---- shared/tecc_consts.svh ----
// register indices, field positions and reset values of the timer/event counter control block
// assumes byte address = 4 * register index on a 32-bit AXI4-Lite slave
`ifndef TECC_CONSTS_SVH
`define TECC_CONSTS_SVH
`define TECC_CTRL0_IDX   10'h00E
`define TECC_CTRL1_IDX   10'h011
`define TECC_CTRL2_IDX   10'h02E
`define TECC_PRE0_IDX    10'h040
`define TECC_PRE1_IDX    10'h041
`define TECC_PRE2_IDX    10'h042
`define TECC_CNT0_IDX    10'h043
`define TECC_CNT1_IDX    10'h044
`define TECC_CNT2_IDX    10'h045
`define TECC_STAT_IDX    10'h046
`define TECC_MASK_IDX    10'h047
`define TECC_PSC_LSB     0
`define TECC_EDGE_BIT    3
`define TECC_RUN_BIT     4
`define TECC_SRC_BIT     5
`define TECC_MODE_LSB    6
`define TECC_CTRL02_MASK 8'hDF
`define TECC_CTRL1_MASK  8'hF8
`define TECC_CTRL_RST    8'h00
`define TECC_PSC_W       7
`define TECC_DIV4_CODE   3'h2
`define TECC_RESP_OKAY   2'h0
`define TECC_RESP_SLVERR 2'h2
`endif

// ---- shared/tecc_pkg.sv ----
// types shared by the timer/event counter control block
// assumes nothing beyond the constants header
`default_nettype none
package tecc_pkg;
    typedef enum logic [1:0] {
        MODE_NONE  = 2'b00,
        MODE_EVENT = 2'b01,
        MODE_TIMER = 2'b10,
        MODE_PULSE = 2'b11
    } tecc_mode_t;
    typedef enum logic [2:0] {
        PW_IDLE = 3'b001,
        PW_MEAS = 3'b010,
        PW_HOLD = 3'b100
    } tecc_pw_t;
endpackage
`default_nettype wire

// ---- shared/tecc_cnt_if.sv ----
// link between the control top and one counter channel
// assumes all signals are on CLK
`default_nettype none
interface tecc_cnt_if #(parameter int W = 16);
    logic                 tick;
    logic                 rise;
    logic                 fall;
    tecc_pkg::tecc_mode_t mode;
    logic                 edge_sel;
    logic                 run;
    logic                 load;
    logic [W-1:0]         preload;
    logic [W-1:0]         cnt;
    logic                 ovf;
    logic                 done;
    modport ctl (output tick, rise, fall, mode, edge_sel, run, load, preload, input cnt, ovf, done);
    modport chn (input tick, rise, fall, mode, edge_sel, run, load, preload, output cnt, ovf, done);
endinterface
`default_nettype wire

// ---- src/tecc_counter.sv ----
// one count-up counter channel: event, timer and pulse width modes
// assumes pin edges already synchronised, tick is a one-cycle enable
`default_nettype none
module tecc_counter #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic srst,
    tecc_cnt_if.chn  c
);
    import tecc_pkg::*;

    logic [W-1:0] cnt_q;
    tecc_pw_t     pw_q;
    logic         ovf_q;
    logic         done_q;
    logic         start;
    logic         stop;
    logic         inc;

    assign start  = c.edge_sel ? c.rise : c.fall;
    assign stop   = c.edge_sel ? c.fall : c.rise;
    assign c.cnt  = cnt_q;
    assign c.ovf  = ovf_q;
    assign c.done = done_q;

    always_comb begin
        case (c.mode)
            MODE_EVENT: inc = c.run && (c.edge_sel ? c.fall : c.rise);
            MODE_TIMER: inc = c.run && c.tick;
            MODE_PULSE: inc = c.run && pw_q == PW_MEAS && !stop && c.tick;
            default:    inc = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // single-shot measurement; hold state blocks a restart until run drops
    always_ff @(posedge clk) begin
        if (srst) begin
            pw_q <= PW_IDLE;
        end else begin
            case (pw_q)
                PW_IDLE: if (c.run && c.mode == MODE_PULSE && start) pw_q <= PW_MEAS;
                PW_MEAS: begin
                    if (!c.run || c.mode != MODE_PULSE) pw_q <= PW_IDLE;
                    else if (stop) pw_q <= PW_HOLD;
                end
                PW_HOLD: if (!c.run) pw_q <= PW_IDLE;
                default: pw_q <= PW_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= pw_q == PW_MEAS && stop && c.run && c.mode == MODE_PULSE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= '0;
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= 1'b0;
            if (c.load) begin
                cnt_q <= c.preload;
            end else if (inc) begin
                if (&cnt_q) begin
                    cnt_q <= c.preload;
                    ovf_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_meas_stop;
        pw_q == PW_MEAS && stop && c.run && c.mode == MODE_PULSE;
    endsequence
    sequence s_done_hold;
        done_q && pw_q == PW_HOLD ##1 pw_q != PW_MEAS;
    endsequence

    AST_HOLD: assert property (@(posedge clk) disable iff (srst)
        !c.run && !c.load |=> cnt_q == $past(cnt_q))
        else $error("count moved while stopped");
    AST_OVF: assert property (@(posedge clk) disable iff (srst)
        inc && !c.load && &cnt_q |=> ovf_q && cnt_q == $past(c.preload))
        else $error("overflow did not reload");
    AST_EVT: assert property (@(posedge clk) disable iff (srst)
        c.mode == MODE_EVENT && c.run && !c.load && !(&cnt_q) && (c.edge_sel ? c.fall : c.rise)
        |=> cnt_q == $past(cnt_q) + 1'b1)
        else $error("event edge not counted");
    AST_TMR: assert property (@(posedge clk) disable iff (srst)
        c.mode == MODE_TIMER && c.run && c.tick && !c.load && !(&cnt_q)
        |=> cnt_q == $past(cnt_q) + 1'b1)
        else $error("timer tick not counted");
    AST_PW_DONE: assert property (@(posedge clk) disable iff (srst)
        s_meas_stop |=> s_done_hold)
        else $error("measurement did not end on stop edge");
endmodule // tecc_counter
`default_nettype wire

// ---- sim/tecc_pin_src.sv ----
// partner: level source on the three counter pins and a free 32768Hz oscillator
// assumes the bench calls set_pin from its own clocked sequence
`default_nettype none
module tecc_pin_src (
    // clock
    input  wire logic       clk,
    // pins
    output var  logic [2:0] pin,
    output var  logic       osc
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pin = 3'h0;
        osc = 1'b0;
        forever #15259 osc = ~osc;
    end
    // new level after an edge, held past the sync and edge delay
    task automatic set_pin(input int i, input logic lvl);
        @(posedge clk);
        pin[i] <= lvl;
        repeat (8) @(posedge clk);
    endtask
endmodule // tecc_pin_src
`default_nettype wire

// ---- sim/tecc_top_tb.sv ----
// bench for the timer/event counter control: axi4-lite tasks and scenario sequence
// assumes tecc_pin_src drives the counter pins and oscillator
`include "tecc_consts.svh"
`default_nettype none
module tecc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, srst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, irq, osc;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v, p;
    logic [1:0]  bresp, rresp, r, freq_divider_out;
    logic [2:0]  pin;
    logic [6:0]  pwm;
    int          bad_count, num_checks;
    tecc_top DUT (.CLK(clk), .SRST(srst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
        .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
        .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .CTR_EVENT_PIN(pin), .RTC_OSC_IN(osc),
        .FREQ_DIVIDER_OUT(freq_divider_out), .PWM_PRESCALE(pwm), .IRQ(irq));
    tecc_pin_src SRC (.clk(clk), .pin(pin), .osc(osc));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic inr(input logic [31:0] lo, input logic [31:0] hi);
        num_checks++;
        if ((v >= lo && v <= hi) !== 1'b1) begin
            bad_count++;
            $display("mismatch at %0t: count %h outside %h..%h", $time, v, lo, hi);
        end
    endtask
    task automatic wr(input logic [9:0] i, input logic [31:0] d);
        @(posedge clk);
        awaddr <= {i, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] i);
        @(posedge clk);
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rc(input logic [9:0] i, input logic [31:0] e);
        rd(i);
        chk(v, e);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        bad_count++;
        $display("mismatch at %0t: timeout", $time);
        test_done;
    end
    initial begin
        {srst, awvalid, wvalid, bready, arvalid, rready} = 6'h3F & 6'h20;
        {awaddr, araddr, wdata} = '0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        rc(`TECC_CTRL0_IDX, 32'h0000_0000);
        wr(`TECC_CTRL0_IDX, 32'h0000_002F);
        rc(`TECC_CTRL0_IDX, 32'h0000_000F);
        wr(`TECC_CTRL1_IDX, 32'h0000_002F);
        rc(`TECC_CTRL1_IDX, 32'h0000_0028);
        wr(`TECC_CTRL2_IDX, 32'h0000_002F);
        rc(`TECC_CTRL2_IDX, 32'h0000_000F);
        wr(10'h3FF, 32'h0000_0001);
        chk(r, `TECC_RESP_SLVERR);
        rd(10'h3FF);
        chk(r, `TECC_RESP_SLVERR);
        @(posedge clk);
        p = pwm;
        @(posedge clk);
        chk(pwm, 7'(p[6:0] + 7'h01));
        $display("test registers done");
        // timer mode on counter 2 at every divide code
        for (int k = 0; k < 8; k++) begin
            wr(`TECC_CTRL2_IDX, 32'h0000_0000);
            wr(`TECC_PRE2_IDX, 32'h0000_0000);
            wr(`TECC_CTRL2_IDX, 32'h0000_0090 | k);
            repeat (200) @(posedge clk);
            wr(`TECC_CTRL2_IDX, 32'h0000_0080 | k);
            rd(`TECC_CNT2_IDX);
            inr((200 >> k) - 1, (212 >> k) + 1);
            p = v;
            repeat (20) @(posedge clk);
            rc(`TECC_CNT2_IDX, p);
        end
        $display("test timer done");
        for (int e = 0; e < 2; e++) begin
            wr(`TECC_CTRL0_IDX, 32'h0000_0000);
            wr(`TECC_PRE0_IDX, 32'h0000_0000);
            wr(`TECC_CTRL0_IDX, 32'h0000_0050 | (e << 3));
            SRC.set_pin(0, 1'b1);
            rc(`TECC_CNT0_IDX, e == 0);
            SRC.set_pin(0, 1'b0);
            rc(`TECC_CNT0_IDX, 32'h0000_0001);
        end
        // two rising edges from one below all ones
        wr(`TECC_CTRL0_IDX, 32'h0000_0000);
        wr(`TECC_PRE0_IDX, 32'h0000_FFFE);
        wr(`TECC_CTRL0_IDX, 32'h0000_0050);
        repeat (2) begin
            SRC.set_pin(0, 1'b1);
            SRC.set_pin(0, 1'b0);
        end
        rc(`TECC_CNT0_IDX, 32'h0000_FFFE);
        rc(`TECC_STAT_IDX, 32'h0000_0001);
        chk(irq, 1'b0);
        chk(freq_divider_out[0], 1'b1);
        wr(`TECC_MASK_IDX, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        wr(`TECC_STAT_IDX, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        $display("test event and overflow done");
        wr(`TECC_CTRL1_IDX, 32'h0000_00D8);
        SRC.set_pin(1, 1'b1);
        repeat (32) @(posedge clk);
        SRC.set_pin(1, 1'b0);
        rd(`TECC_CNT1_IDX);
        p = v;
        inr(32'h0000_0008, 32'h0000_000C);
        rc(`TECC_CTRL1_IDX, 32'h0000_00C8);
        SRC.set_pin(1, 1'b1);
        SRC.set_pin(1, 1'b0);
        rc(`TECC_CNT1_IDX, p);
        $display("test pulse width done");
        // oscillator source: two or three ticks from one below all ones
        wr(`TECC_CTRL1_IDX, 32'h0000_0000);
        wr(`TECC_PRE1_IDX, 32'h0000_FFFE);
        wr(`TECC_CTRL1_IDX, 32'h0000_00B0);
        repeat (6200) @(posedge clk);
        wr(`TECC_CTRL1_IDX, 32'h0000_00A0);
        rd(`TECC_CNT1_IDX);
        inr(32'h0000_FFFE, 32'h0000_FFFF);
        chk(freq_divider_out[1], 1'b1);
        $display("test oscillator source done");
        test_done;
    end
endmodule // tecc_top_tb
`default_nettype wire
